// ==== hdl/ea_pkg.sv ====
// Package for the effective-address and length decoder.
// Assumes a byte-wide memory on a 16-bit address bus with one-cycle reads.
package ea_pkg;
   localparam logic [15:0] reset_pc = 16'h0000;
   localparam logic [7:0] direct_page = 8'h00;
   localparam logic [7:0] op_add_b_into_a = 8'h1b;
   localparam logic [7:0] op_add_one_to_b = 8'h5c;
   localparam logic [7:0] op_add_one_to_index = 8'h08;
   localparam logic [7:0] op_load_double_accum = 8'hcc;
   localparam logic [7:0] op_load_index_reg = 8'hce;
   localparam logic [7:0] op_jump_absolute = 8'h7e;
   localparam logic [7:0] op_jump_subroutine = 8'hbd;
   localparam logic [7:0] op_inc_mem_ext = 8'h7c;
   localparam logic [7:0] op_count_down_ext = 8'h7a;
   localparam logic [7:0] op_zero_memory_ext = 8'h7f;
   localparam logic [7:0] op_invert_memory_ext = 8'h73;
   localparam logic [7:0] reset_byte = 8'h00;
   localparam logic [15:0] reset_word = 16'h0000;
   typedef enum logic [2:0] {
      mode_inherent = 3'h0,
      mode_immediate = 3'h1,
      mode_direct = 3'h2,
      mode_extended = 3'h3,
      mode_relative = 3'h4,
      mode_indexed = 3'h5
   } addr_mode_t;
   typedef enum logic [3:0] {
      op_none = 4'h0, op_add_ab = 4'h1, op_inc_b = 4'h2, op_inc_x = 4'h3,
      op_load_a = 4'h4, op_load_b = 4'h5, op_load_d = 4'h6, op_load_x = 4'h7,
      op_jump = 4'h8, op_branch = 4'h9, op_rmw_inc = 4'ha, op_rmw_dec = 4'hb,
      op_rmw_clr = 4'hc, op_rmw_com = 4'hd, op_read = 4'he
   } op_kind_t;
endpackage

// ==== hdl/ea_decode_if.sv ====
// Interface carrying opcode decode results to the sequencer.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface ea_decode_if;
   logic [7:0] opcode;
   ea_pkg::addr_mode_t mode;
   ea_pkg::op_kind_t kind;
   logic wide;
   modport decoder (input opcode, output mode, output kind, output wide);
   modport user (output opcode, input mode, input kind, input wide);
endinterface
`default_nettype wire

// ==== hdl/ea_opcode_decoder.sv ====
// Combinational opcode decoder: mode, operation kind and operand width.
// Assumes the opcode is stable while it is decoded.
`timescale 1ns/1ps
`default_nettype none
module ea_opcode_decoder (
   ea_decode_if.decoder dec // Opcode in, decode out
);
   import ea_pkg::*;
   always_comb begin
      dec.mode = mode_inherent;
      dec.kind = op_none;
      dec.wide = 1'b0;
      if (dec.opcode == op_add_b_into_a) begin
         dec.kind = op_add_ab;
      end else if (dec.opcode == op_add_one_to_b) begin
         dec.kind = op_inc_b;
      end else if (dec.opcode == op_add_one_to_index) begin
         dec.kind = op_inc_x;
      end else if (dec.opcode == op_load_double_accum) begin
         dec.mode = mode_immediate;
         dec.kind = op_load_d;
         dec.wide = 1'b1;
      end else if (dec.opcode == op_load_index_reg) begin
         dec.mode = mode_immediate;
         dec.kind = op_load_x;
         dec.wide = 1'b1;
      end else if (dec.opcode == op_jump_absolute || dec.opcode == op_jump_subroutine) begin
         dec.mode = mode_extended;
         dec.kind = op_jump;
      end else if (dec.opcode == op_inc_mem_ext) begin
         dec.mode = mode_extended;
         dec.kind = op_rmw_inc;
      end else if (dec.opcode == op_count_down_ext) begin
         dec.mode = mode_extended;
         dec.kind = op_rmw_dec;
      end else if (dec.opcode == op_zero_memory_ext) begin
         dec.mode = mode_extended;
         dec.kind = op_rmw_clr;
      end else if (dec.opcode == op_invert_memory_ext) begin
         dec.mode = mode_extended;
         dec.kind = op_rmw_com;
      end else if (dec.opcode[7:4] == 4'h2 || dec.opcode == 8'h8d) begin
         dec.mode = mode_relative;
         dec.kind = op_branch;
      end else if (dec.opcode[7:6] == 2'b10 || dec.opcode[7:6] == 2'b11) begin
         // Accumulator group: column bits pick the mode
         dec.kind = (dec.opcode[3:0] == 4'h6) ? (dec.opcode[6] ? op_load_b : op_load_a) : op_read;
         case (dec.opcode[5:4])
            2'b00: dec.mode = mode_immediate;
            2'b01: dec.mode = mode_direct;
            2'b10: dec.mode = mode_indexed;
            default: dec.mode = mode_extended;
         endcase
         dec.wide = (dec.opcode[5:4] == 2'b00) && (dec.opcode[3:0] == 4'h3);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/effective_address_gen.sv ====
// Effective-address generator and instruction-length sequencer.
// Assumes memory returns read data the cycle after the address is driven.
// Functional notes
// - Addressing mode comes only from the opcode byte.
// - Non-inherent modes form a 16-bit address driven during the reference cycle; here immediate forms none and relative never drives its target.
// - Inherent instructions are one byte with no operand fetch.
// - 1B adds B into A, 5C increments B, 08 increments index.
// - Immediate operand is one byte for 8-bit, two for 16-bit targets.
// - CC loads double accumulator, CE loads index, from two following bytes.
// - Extended takes a full 16-bit address from two bytes; three bytes long.
// - Direct forces high byte zero, low byte from operand; two bytes long.
// - Direct accesses stay within 0000 to 00FF.
// - Read-modify-write ops are extended only, writing back to same location.
// - Relative only for branches, offset added to already advanced counter.
// - Zero offset continues with next instruction regardless of condition.
// - Branch is two bytes, offset signed from -128 to +127.
// - Reach is -126 to +129 from the branch opcode address.
// - Jump 7E loads program counter from following two bytes.
// - Double accumulator is A high byte, B low byte.
`timescale 1ns/1ps
`default_nettype none
module effective_address_gen (
   input wire logic core_clk, // Core clock, 10 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [7:0] mem_rdata, // Read data from memory
   input wire logic branch_taken, // Condition result for current branch
   output logic [15:0] mem_addr, // Address bus
   output logic [7:0] mem_wdata, // Write data
   output logic mem_we, // Write strobe
   output logic [15:0] program_counter, // Program counter
   output logic [7:0] accumulator_a, // Accumulator A
   output logic [7:0] accumulator_b, // Accumulator B
   output logic [15:0] index_reg, // Index register
   output logic [15:0] eff_addr, // Last effective address
   output ea_pkg::addr_mode_t cur_mode, // Mode of current instruction
   output logic instr_done // Pulse at the end of each instruction
);
   import ea_pkg::*;
   typedef enum logic [6:0] {
      st_fetch = 7'b0000001,
      st_op_hi = 7'b0000010,
      st_op_lo = 7'b0000100,
      st_mem_rd = 7'b0001000,
      st_mem_wr = 7'b0010000,
      st_exec = 7'b0100000,
      st_wait = 7'b1000000
   } state_t;
   state_t state;
   logic [7:0] opcode;
   logic [7:0] hi_byte;
   logic [7:0] mem_data;
   logic [15:0] operand;
   ea_decode_if dec_bus();
   ea_opcode_decoder u_decoder (
      .dec(dec_bus.decoder)
   );
   assign dec_bus.opcode = (state == st_op_hi) ? mem_rdata : opcode;
   ////////////////////////////////////////////////////////////////////////
   // Operand word assembled high byte first
   assign operand = {hi_byte, mem_rdata};
   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= st_fetch;
         program_counter <= reset_pc;
         opcode <= reset_byte;
         hi_byte <= reset_byte;
         eff_addr <= reset_word;
         mem_data <= reset_byte;
         cur_mode <= mode_inherent;
         instr_done <= 1'b0;
      end else begin
         instr_done <= 1'b0;
         case (state)
            st_fetch: begin
               program_counter <= program_counter + 16'h0001;
               state <= st_op_hi;
            end
            st_op_hi: begin
               opcode <= mem_rdata;
               cur_mode <= dec_bus.mode;
               if (dec_bus.mode == mode_inherent) begin
                  state <= st_exec;
               end else begin
                  program_counter <= program_counter + 16'h0001;
                  state <= st_op_lo;
               end
            end
            st_op_lo: begin
               hi_byte <= mem_rdata;
               state <= st_exec;
               if (cur_mode == mode_direct) begin
                  eff_addr <= {direct_page, mem_rdata};
                  state <= st_mem_rd;
               end else if (cur_mode == mode_relative) begin
                  // Counter already points past the offset byte
                  eff_addr <= program_counter + {{8{mem_rdata[7]}}, mem_rdata};
               end else if (cur_mode == mode_indexed) begin
                  eff_addr <= index_reg + {8'h00, mem_rdata};
                  state <= st_mem_rd;
               end else if (cur_mode == mode_extended || dec_bus.wide) begin
                  program_counter <= program_counter + 16'h0001;
                  state <= st_wait;
               end
            end
            st_wait: begin
               if (cur_mode == mode_extended) begin
                  eff_addr <= operand;
                  state <= (dec_bus.kind == op_jump) ? st_exec : st_mem_rd;
               end else begin
                  // Second immediate byte is only on the bus now, so keep it for exec
                  mem_data <= mem_rdata;
                  state <= st_exec;
               end
            end
            st_mem_rd: begin
               state <= st_mem_wr;
            end
            st_mem_wr: begin
               mem_data <= mem_rdata;
               state <= st_exec;
            end
            st_exec: begin
               if (dec_bus.kind == op_jump) begin
                  program_counter <= eff_addr;
               end else if (dec_bus.kind == op_branch && branch_taken) begin
                  program_counter <= eff_addr;
               end
               instr_done <= 1'b1;
               state <= st_fetch;
            end
            default: state <= st_fetch;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Register file updates
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         accumulator_a <= reset_byte;
         accumulator_b <= reset_byte;
         index_reg <= reset_word;
      end else if (state == st_exec && cur_mode == mode_inherent) begin
         if (dec_bus.kind == op_add_ab) begin
            accumulator_a <= accumulator_a + accumulator_b;
         end else if (dec_bus.kind == op_inc_b) begin
            accumulator_b <= accumulator_b + 8'h01;
         end else if (dec_bus.kind == op_inc_x) begin
            index_reg <= index_reg + 16'h0001;
         end
      end else if (state == st_exec && cur_mode == mode_immediate) begin
         if (dec_bus.kind == op_load_d) begin
            {accumulator_a, accumulator_b} <= {hi_byte, mem_data};
         end else if (dec_bus.kind == op_load_x) begin
            index_reg <= {hi_byte, mem_data};
         end else if (dec_bus.kind == op_load_a) begin
            accumulator_a <= hi_byte;
         end else if (dec_bus.kind == op_load_b) begin
            accumulator_b <= hi_byte;
         end
      end else if (state == st_exec && dec_bus.kind == op_load_a) begin
         accumulator_a <= mem_data;
      end else if (state == st_exec && dec_bus.kind == op_load_b) begin
         accumulator_b <= mem_data;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Read-modify-write result, formed from the byte just read
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mem_wdata <= reset_byte;
      end else if (state == st_mem_wr) begin
         // Result goes back to the location just read
         case (dec_bus.kind)
            op_rmw_inc: mem_wdata <= mem_rdata + 8'h01;
            op_rmw_dec: mem_wdata <= mem_rdata - 8'h01;
            op_rmw_clr: mem_wdata <= 8'h00;
            op_rmw_com: mem_wdata <= ~mem_rdata;
            default: mem_wdata <= mem_rdata;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Address bus: program counter while fetching, effective address for references
   always_comb begin
      mem_addr = program_counter;
      mem_we = 1'b0;
      if (state == st_mem_rd) begin
         mem_addr = eff_addr;
      end else if (state == st_exec && cur_mode != mode_inherent && cur_mode != mode_relative
                   && dec_bus.kind != op_jump) begin
         mem_addr = eff_addr;
         mem_we = (dec_bus.kind >= op_rmw_inc) && (dec_bus.kind <= op_rmw_com);
      end
   end
endmodule
`default_nettype wire

// ==== testbench/ea_checker.sv ====
// Port-level checks for the effective-address generator.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ea_checker (
   input wire logic core_clk, // Core clock
   input wire logic rst_n, // Reset, active low
   input wire logic [15:0] mem_addr, // Address bus
   input wire logic mem_we, // Write strobe
   input wire logic [15:0] program_counter, // Program counter
   input wire logic [15:0] eff_addr, // Effective address
   input wire ea_pkg::addr_mode_t cur_mode, // Current mode
   input wire logic instr_done // End of instruction
);
   import ea_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] last_pc;
   logic [15:0] rel_delta;
   // Counter value at the previous instruction end, so lengths can be judged
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         last_pc <= reset_pc;
      end else if (instr_done) begin
         last_pc <= program_counter;
      end
   end
   assign rel_delta = program_counter - last_pc - 16'h0002;
   ////////////////////////////////////////////////////////////////////////////
   a_done_spacing: assert property (instr_done |=> !instr_done ##1 !instr_done)
      else $error("instruction end pulses too close");
   a_inherent_len: assert property (instr_done && cur_mode == mode_inherent
      |-> program_counter == last_pc + 16'h0001) else $error("inherent length wrong");
   a_direct_len: assert property (instr_done && cur_mode == mode_direct
      |-> program_counter == last_pc + 16'h0002) else $error("direct length wrong");
   a_direct_page: assert property (instr_done && cur_mode == mode_direct
      |-> eff_addr[15:8] == direct_page) else $error("direct address off page");
   a_branch_reach: assert property (instr_done && cur_mode == mode_relative
      |-> rel_delta[15:7] == 9'h000 || rel_delta[15:7] == 9'h1ff) else $error("branch reach");
   a_rmw_mode: assert property (mem_we |-> cur_mode == mode_extended)
      else $error("store outside extended mode");
   a_rmw_target: assert property (mem_we |-> mem_addr == eff_addr
      && $past(mem_addr, 2) == eff_addr) else $error("store not at location read");
   a_ext_len: assert property (instr_done && cur_mode == mode_extended
      |-> program_counter == last_pc + 16'h0003 || program_counter == eff_addr)
      else $error("extended length or jump target wrong");
   a_we_single: assert property (mem_we |=> !mem_we)
      else $error("store strobe longer than one cycle");
   a_bus_source: assert property (mem_addr == program_counter || mem_addr == eff_addr)
      else $error("address bus from unknown source");
endmodule
bind effective_address_gen ea_checker ea_checker_i (.core_clk(core_clk), .rst_n(rst_n),
   .mem_addr(mem_addr), .mem_we(mem_we), .program_counter(program_counter),
   .eff_addr(eff_addr), .cur_mode(cur_mode), .instr_done(instr_done));
`default_nettype wire

// ==== testbench/mem_model.sv ====
// Byte-wide program and data memory for the address generator.
// Assumes reads answer the cycle after the address, writes land on the edge.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic core_clk, // Core clock
   input wire logic [15:0] mem_addr, // Address bus
   input wire logic [7:0] mem_wdata, // Write data
   input wire logic mem_we, // Write strobe
   output logic [7:0] mem_rdata // Read data
);
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h00;
      end
   end
   // Plain always: the bench preloads this array from its own process
   always @(posedge core_clk) begin
      mem_rdata <= mem[mem_addr];
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench: runs a short program through the generator.
// Assumes the memory model answers every address with no wait.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ea_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic branch_taken = 1'b0;
   logic [7:0] mem_rdata, mem_wdata, accumulator_a, accumulator_b;
   logic [15:0] mem_addr, program_counter, index_reg, eff_addr;
   logic mem_we, instr_done;
   addr_mode_t cur_mode;
   int n_errors = 0;
   int checks = 0;
   logic [255:0] prog = 256'hcc12341b5c08ce100008862296807f0050730051_7c00527a005320002000207f;
   always #50 core_clk = ~core_clk;
   effective_address_gen effective_address_gen_i (.core_clk(core_clk), .rst_n(rst_n),
      .mem_rdata(mem_rdata), .branch_taken(branch_taken), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .program_counter(program_counter),
      .accumulator_a(accumulator_a), .accumulator_b(accumulator_b), .index_reg(index_reg),
      .eff_addr(eff_addr), .cur_mode(cur_mode), .instr_done(instr_done));
   mem_model mem_model_i (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_we(mem_we), .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Sampled on the falling edge so the pulse and its results have settled
   task automatic step;
      int i;
      i = 0;
      @(negedge core_clk);
      while (instr_done !== 1'b1 && i < 40) begin
         @(negedge core_clk);
         i++;
      end
      chk("instr_done", 16'h0001, {15'h0000, instr_done});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_inherent_imm;
      step();
      chk("double", 16'h1234, {accumulator_a, accumulator_b});
      chk("pc", 16'h0003, program_counter);
      step();
      chk("acc_a", 16'h0046, {8'h00, accumulator_a});
      chk("pc", 16'h0004, program_counter);
      chk("mode", {13'h0000, mode_inherent}, {13'h0000, cur_mode});
      step();
      chk("acc_b", 16'h0035, {8'h00, accumulator_b});
      step();
      chk("index", 16'h0001, index_reg);
      step();
      chk("index", 16'h1000, index_reg);
      step();
      chk("index", 16'h1001, index_reg);
      step();
      chk("acc_a", 16'h0022, {8'h00, accumulator_a});
      chk("pc", 16'h000c, program_counter);
   endtask
   task automatic t_direct;
      step();
      chk("acc_a", 16'h005a, {8'h00, accumulator_a});
      chk("ea", 16'h0080, eff_addr);
      chk("pc", 16'h000e, program_counter);
   endtask
   task automatic t_rmw;
      logic [7:0] exp [4] = '{8'h00, 8'hf0, 8'h08, 8'hff};
      for (int k = 0; k < 4; k++) begin
         step();
         chk("ea", 16'h0050 + 16'(k), eff_addr);
         chk("pc", 16'h0011 + 16'(3 * k), program_counter);
         chk("mem", {8'h00, exp[k]}, {8'h00, mem_model_i.mem[16'h0050 + 16'(k)]});
      end
   endtask
   task automatic t_branch;
      @(posedge core_clk);
      branch_taken <= 1'b1;
      step();
      chk("pc", 16'h001c, program_counter);
      @(posedge core_clk);
      branch_taken <= 1'b0;
      step();
      chk("pc", 16'h001e, program_counter);
      @(posedge core_clk);
      branch_taken <= 1'b1;
      step();
      chk("pc", 16'h009f, program_counter);
      chk("mode", {13'h0000, mode_relative}, {13'h0000, cur_mode});
   endtask
   task automatic t_jump;
      step();
      chk("pc", 16'h0100, program_counter);
      step();
      chk("pc", 16'h0082, program_counter);
   endtask
   initial begin
      #1;
      for (int i = 0; i < 32; i++) begin
         mem_model_i.mem[i] = prog[8 * (31 - i) +: 8];
      end
      mem_model_i.mem[16'h0080] = 8'h5a;
      mem_model_i.mem[16'h0050] = 8'h55;
      mem_model_i.mem[16'h0051] = 8'h0f;
      mem_model_i.mem[16'h0052] = 8'h07;
      {mem_model_i.mem[16'h009f], mem_model_i.mem[16'h00a0]} = 16'h7e01;
      {mem_model_i.mem[16'h0100], mem_model_i.mem[16'h0101]} = 16'h2080;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_inherent_imm();
      t_direct();
      t_rmw();
      t_branch();
      t_jump();
      end_sim();
   end
   initial begin
      #400000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
